/* bench/fpe_cpu.sv */
`timescale 1ns/1ns
module fpe_cpu (
  input wire logic clk,
  output fpe_pkg::fpe_req_t req,
  input wire logic [31:0] rdata
);
  initial req = '0;
  // ====================
  // bus cycles
  // one request stands for exactly one edge, then idles for one cycle
  task automatic acc(input logic w, input logic rs, input logic [15:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    req <= '{wr: w, rd: !w, reg_sel: rs, addr: {16'h0000, a},
             wdata: {24'h000000, d}};
    @(posedge clk);
    req <= '0;
    #1 q = rdata;
  endtask
  // ====================
  // command sequences
  task automatic pre(input logic [7:0] c);
    logic [31:0] q;
    acc(1'b1, 1'b0, 16'h5400, 8'hAA, q);
    acc(1'b1, 1'b0, 16'hAA00, 8'h55, q);
    acc(1'b1, 1'b0, 16'h5400, c, q);
  endtask
  // caller waits for ready first; writes issued while busy are ignored
  task automatic perase(input logic [15:0] a);
    logic [31:0] q;
    pre(8'h6A);
    pre(8'h6A);
    acc(1'b1, 1'b0, a, 8'h6A, q);
  endtask
endmodule // fpe_cpu

/* bench/fpe_ctrl_test.sv */
`timescale 1ns/1ns
module fpe_ctrl_test;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cold_nrst = 1'b0;
  logic op_fail = 1'b0;
  logic [5:0] prot_init = 6'h3F;
  logic rdy_ff, array_erase_ff, id_mode_ff;
  logic [31:0] rdata_ff, q;
  fpe_pkg::fpe_req_t req;
  int num_errors = 0;
  int checks = 0;
  always #25 clk = ~clk;
  // identify words stay at their defaults 0x11..0x44
  fpe_ctrl #(.FULL_CYC(20)) i_fpe_ctrl (.clk(clk), .nrst(nrst),
    .cold_nrst(cold_nrst), .req(req), .op_fail(op_fail),
    .prot_init(prot_init), .rdata_ff(rdata_ff), .rdy_ff(rdy_ff),
    .array_erase_ff(array_erase_ff), .id_mode_ff(id_mode_ff));
  fpe_cpu i_fpe_cpu (.clk(clk), .req(req), .rdata(rdata_ff));
  // ====================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic rs, input logic [15:0] a);
    i_fpe_cpu.acc(1'b0, rs, a, 8'h00, q);
  endtask
  task automatic rst(input logic [5:0] p);
    @(posedge clk);
    prot_init <= p;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic wait_rdy();
    for (int i = 0; i < 3000 && rdy_ff !== 1'b1; i++) @(posedge clk);
    #1;
    if (rdy_ff !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: ready wait ran out", $time);
    end
  endtask
  function automatic logic [31:0] st(input logic [5:0] f);
    return {10'h000, f, 15'h0000, 1'b1};
  endfunction
  // ====================
  // scenarios
  task automatic t_regs();
    rd(1'b1, 16'h0020);
    check(q, st(6'h3F));
    i_fpe_cpu.acc(1'b1, 1'b1, 16'h0020, 8'hFE, q);
    rd(1'b1, 16'h0020);
    check(q, st(6'h3F));
    rd(1'b1, 16'h0004);
    check(q, 32'h00000000);
    rd(1'b1, 16'h0000);
    check(q, 32'h00000001);
    i_fpe_cpu.acc(1'b1, 1'b1, 16'h0000, 8'h00, q);
    rst(6'h3F);
    rd(1'b1, 16'h0000);
    check(q, 32'h00000000);
    @(posedge clk);
    cold_nrst <= 1'b0;
    @(posedge clk);
    cold_nrst <= 1'b1;
    rd(1'b1, 16'h0000);
    check(q, 32'h00000001);
    $display("done t_regs");
  endtask
  task automatic t_ident();
    i_fpe_cpu.pre(8'h90);
    for (int n = 0; n < 4; n++) begin
      i_fpe_cpu.acc(1'b1, 1'b0, {n[1:0], 14'h0000}, 8'h00, q);
      rd(1'b0, 16'h0100);
      check(q, 32'h11 * (n + 1));
      check({31'h0, id_mode_ff}, 32'h1);
    end
    i_fpe_cpu.acc(1'b1, 1'b0, 16'h0000, 8'hF0, q);
    check({31'h0, id_mode_ff}, 32'h0);
    rd(1'b0, 16'h0100);
    check(q, 32'h0);
    $display("done t_ident");
  endtask
  task automatic t_full();
    i_fpe_cpu.perase(16'h0000);
    @(posedge clk);
    #1;
    check({30'h0, rdy_ff, array_erase_ff}, 32'h1);
    wait_rdy();
    rd(1'b1, 16'h0020);
    check(q, 32'h00000001);
    rd(1'b0, 16'h0000);
    check(q, 32'h00000000);
    $display("done t_full");
  endtask
  task automatic t_group();
    rst(6'h3B);
    i_fpe_cpu.perase(16'h0000);
    @(posedge clk);
    #1;
    check({30'h0, rdy_ff, array_erase_ff}, 32'h0);
    i_fpe_cpu.pre(8'h90);
    i_fpe_cpu.acc(1'b1, 1'b0, 16'h4000, 8'h00, q);
    check({31'h0, id_mode_ff}, 32'h0);
    wait_rdy();
    rd(1'b1, 16'h0020);
    check(q, st(6'h30));
    i_fpe_cpu.perase(16'h4000);
    wait_rdy();
    rd(1'b1, 16'h0020);
    check(q, st(6'h00));
    $display("done t_group");
  endtask
  // security off: all flags set still takes the grouped path
  task automatic t_sec();
    rst(6'h3F);
    i_fpe_cpu.acc(1'b1, 1'b1, 16'h0000, 8'h00, q);
    i_fpe_cpu.perase(16'h4000);
    @(posedge clk);
    #1;
    check({31'h0, array_erase_ff}, 32'h0);
    wait_rdy();
    rd(1'b1, 16'h0020);
    check(q, st(6'h0F));
    i_fpe_cpu.acc(1'b1, 1'b1, 16'h0000, 8'h01, q);
    $display("done t_sec");
  endtask
  task automatic t_fail();
    rst(6'h3F);
    i_fpe_cpu.perase(16'h0000);
    @(posedge clk);
    op_fail <= 1'b1;
    repeat (2500) @(posedge clk);
    #1;
    check({31'h0, rdy_ff}, 32'h0);
    op_fail <= 1'b0;
    rst(6'h3F);
    check({31'h0, rdy_ff}, 32'h1);
    rd(1'b1, 16'h0020);
    check(q, st(6'h3F));
    $display("done t_fail");
  endtask
  // ====================
  // run control
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    cold_nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_ident();
    t_full();
    t_group();
    t_sec();
    t_fail();
    finish_test();
  end
  // about 10700 cycles expected; cut off well beyond that
  initial begin
    #(30000 * 50);
    num_errors++;
    finish_test();
  end
endmodule // fpe_ctrl_test

/* logic/fpe_ctrl.sv */
`timescale 1ns/1ns
// Overview of operation
// - with security on, protect erase depends on whether all flags are set
// - all flags set: seventh write erases whole array, then protection bits
// - full protect erase done: status reads 0x0000001
// - otherwise clear protection of blocks 3..0 or blocks 5..4, chosen by seventh address
// - grouped erase done: selected group flags read 0
// - command writes ignored while protect erase runs
// - protect erase done returns to read mode
// - ready flag bit 0 is 0 while busy, 1 when done
// - failed operation keeps ready at 0 until hardware reset
// - identify reads return word chosen by address 15:14 of fourth write
// - identify mode stays until read/reset command, protect erase start or hardware reset
// - security register at 0x0000, status register at 0x0020
// - status bits 21-16 are block 5..0 protection; others but bit 0 zero
// - small variant: flag bits 21:20 always read 0
// - security bit resets to 1, only by cold reset
module fpe_ctrl #(
  parameter bit SMALL_VARIANT = 1'b0,
  parameter int FULL_CYC = fpe_pkg::FULL_TIME_US * fpe_pkg::CLK_MHZ,
  parameter logic [31:0] ID_WORD0 = 32'h0000_0011, // arbitrary value
  parameter logic [31:0] ID_WORD1 = 32'h0000_0022, // arbitrary value
  parameter logic [31:0] ID_WORD2 = 32'h0000_0033, // arbitrary value
  parameter logic [31:0] ID_WORD3 = 32'h0000_0044 // arbitrary value
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cold_nrst,
  input wire fpe_pkg::fpe_req_t req,
  input wire logic op_fail,
  input wire logic [fpe_pkg::NBLK-1:0] prot_init,
  output logic [31:0] rdata_ff,
  output logic rdy_ff,
  output logic array_erase_ff,
  output logic id_mode_ff
);

  localparam int NB = fpe_pkg::NBLK;
  localparam int CW = fpe_pkg::CNT_W;
  localparam logic [CW-1:0] FULL_C = CW'(FULL_CYC);
  localparam logic [NB-1:0] AVAIL =
    SMALL_VARIANT ? fpe_pkg::SMALL_MASK : fpe_pkg::FULL_MASK;

  // ==========================================================
  // pin synchronisers
  logic fail_s1_ff, fail_s2_ff;
  logic [NB-1:0] pin_s1_ff, pin_s2_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fail_s1_ff <= 1'b0;
      fail_s2_ff <= 1'b0;
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      fail_s1_ff <= op_fail;
      fail_s2_ff <= fail_s1_ff;
      pin_s1_ff <= prot_init;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // ==========================================================
  // decode
  fpe_pkg::fpe_state_t st_ff, nxt_st;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic full_ff, nxt_full, ph_ff, nxt_ph;
  logic [NB-1:0] prot_ff, nxt_prot, grp_ff, nxt_grp;
  logic [1:0] ld_ff, id_sel_ff, nxt_idsel;
  logic sec_ff, nxt_id;
  logic [31:0] nxt_rdata;

  wire wr_cmd = req.wr & ~req.reg_sel;
  wire rd_flash = req.rd & ~req.reg_sel;
  wire [7:0] dat = req.wdata[7:0];
  wire [7:0] ahi = req.addr[fpe_pkg::ACMD_HI:fpe_pkg::ACMD_LO];
  wire a54 = ahi == fpe_pkg::ADR_54;
  wire is_aa54 = (dat == fpe_pkg::CMD_AA) & a54;
  wire is_55aa = (dat == fpe_pkg::CMD_55) & (ahi == fpe_pkg::ADR_AA);
  wire is_pbe = dat == fpe_pkg::CMD_PBE;
  wire loaded = ld_ff == fpe_pkg::LOAD_DLY;
  wire all_prot = (prot_ff & AVAIL) == AVAIL;
  // group chosen by the seventh write address
  wire [NB-1:0] sel_grp = req.addr[fpe_pkg::GRP_BIT] ?
    fpe_pkg::GRP1_MASK : fpe_pkg::GRP0_MASK;
  wire busy_end = (st_ff == fpe_pkg::S_BUSY) & ~fail_s2_ff & (cnt_ff == '0);
  wire sec_hit = req.reg_sel & (req.addr[7:0] == fpe_pkg::OFS_SEC);
  wire stat_hit = req.reg_sel & (req.addr[7:0] == fpe_pkg::OFS_STAT);
  // bits 21-16 flags, bit 0 ready, rest zero
  wire [31:0] stat_word = {{(32-fpe_pkg::PROT_LO-NB){1'b0}}, prot_ff & AVAIL,
    {(fpe_pkg::PROT_LO-1){1'b0}}, rdy_ff};
  wire [31:0] id_word = id_sel_ff[1] ?
    (id_sel_ff[0] ? ID_WORD3 : ID_WORD2) :
    (id_sel_ff[0] ? ID_WORD1 : ID_WORD0);

  // ==========================================================
  // command sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_full = full_ff;
    nxt_ph = ph_ff;
    nxt_prot = loaded ? prot_ff : (pin_s2_ff & AVAIL);
    nxt_grp = grp_ff;
    nxt_id = id_mode_ff;
    nxt_idsel = id_sel_ff;
    case (st_ff)
      fpe_pkg::S_IDLE: begin
        if (wr_cmd && is_aa54) begin
          nxt_st = fpe_pkg::S_C1;
        end else if (wr_cmd && dat == fpe_pkg::CMD_RST) begin
          nxt_id = 1'b0;
        end else if (wr_cmd && id_mode_ff) begin
          // repeated select write while in identify mode
          nxt_idsel = req.addr[fpe_pkg::IDSEL_HI:fpe_pkg::IDSEL_LO];
        end
      end
      fpe_pkg::S_C1: if (wr_cmd) begin
        nxt_st = is_55aa ? fpe_pkg::S_C2 : fpe_pkg::S_IDLE;
      end
      fpe_pkg::S_C2: if (wr_cmd) begin
        nxt_st = fpe_pkg::S_IDLE;
        if (a54 && dat == fpe_pkg::CMD_ID) begin
          nxt_st = fpe_pkg::S_IDARM;
        end else if (a54 && dat == fpe_pkg::CMD_RST) begin
          nxt_id = 1'b0;
        end else if (a54 && is_pbe) begin
          nxt_st = fpe_pkg::S_C3;
        end
      end
      fpe_pkg::S_IDARM: if (wr_cmd) begin
        nxt_st = fpe_pkg::S_IDLE;
        nxt_id = 1'b1;
        nxt_idsel = req.addr[fpe_pkg::IDSEL_HI:fpe_pkg::IDSEL_LO];
      end
      fpe_pkg::S_C3: if (wr_cmd) begin
        nxt_st = is_aa54 ? fpe_pkg::S_C4 : fpe_pkg::S_IDLE;
      end
      fpe_pkg::S_C4: if (wr_cmd) begin
        nxt_st = is_55aa ? fpe_pkg::S_C5 : fpe_pkg::S_IDLE;
      end
      fpe_pkg::S_C5: if (wr_cmd) begin
        nxt_st = (a54 && is_pbe) ? fpe_pkg::S_C6 : fpe_pkg::S_IDLE;
      end
      fpe_pkg::S_C6: if (wr_cmd) begin
        nxt_st = fpe_pkg::S_IDLE;
        if (is_pbe) begin
          nxt_st = fpe_pkg::S_BUSY;
          nxt_id = 1'b0;
          // full array wipe only under security with all set
          nxt_full = sec_ff & all_prot;
          nxt_ph = 1'b0;
          nxt_grp = sel_grp;
          nxt_cnt = (sec_ff & all_prot) ? FULL_C : fpe_pkg::PBE_CYC;
        end
      end
      fpe_pkg::S_BUSY: begin
        // writes are not looked at here
        if (fail_s2_ff) begin
          nxt_st = fpe_pkg::S_FAIL;
        end else if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - CW'(1);
        end else if (full_ff && !ph_ff) begin
          nxt_ph = 1'b1; // array done, now the protection bits
          nxt_cnt = fpe_pkg::PBE_CYC;
        end else begin
          nxt_st = fpe_pkg::S_IDLE; // back to read mode
          nxt_prot = full_ff ? '0 : (prot_ff & ~grp_ff);
        end
      end
      // stuck until hardware reset
      fpe_pkg::S_FAIL: nxt_st = fpe_pkg::S_FAIL;
      default: nxt_st = fpe_pkg::S_IDLE;
    endcase
  end

  always_comb begin
    nxt_rdata = '0;
    if (req.rd && sec_hit) begin
      nxt_rdata = {31'h0000_0000, sec_ff};
    end else if (req.rd && stat_hit) begin
      nxt_rdata = stat_word;
    end else if (rd_flash && id_mode_ff) begin
      nxt_rdata = id_word;
    end
  end

  // ==========================================================
  // state registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= fpe_pkg::S_IDLE;
      cnt_ff <= '0;
      full_ff <= 1'b0;
      ph_ff <= 1'b0;
      prot_ff <= '0;
      grp_ff <= '0;
      ld_ff <= '0;
      id_mode_ff <= 1'b0;
      id_sel_ff <= '0;
      rdy_ff <= 1'b1;
      array_erase_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      full_ff <= nxt_full;
      ph_ff <= nxt_ph;
      prot_ff <= nxt_prot;
      grp_ff <= nxt_grp;
      ld_ff <= loaded ? ld_ff : ld_ff + 2'h1;
      id_mode_ff <= nxt_id;
      id_sel_ff <= nxt_idsel;
      rdy_ff <= (nxt_st != fpe_pkg::S_BUSY) &&
        (nxt_st != fpe_pkg::S_FAIL);
      array_erase_ff <= (nxt_st == fpe_pkg::S_BUSY) & nxt_full & ~nxt_ph;
      rdata_ff <= nxt_rdata;
    end
  end

  // security bit sees only the cold reset
  always_ff @(posedge clk or negedge cold_nrst) begin
    if (!cold_nrst) begin
      sec_ff <= fpe_pkg::SEC_RST;
    end else if (req.wr && sec_hit) begin
      sec_ff <= req.wdata[0];
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence seventh_write_s;
    st_ff == fpe_pkg::S_C6 && wr_cmd && is_pbe;
  endsequence
  sequence full_last_s;
    busy_end && full_ff && ph_ff;
  endsequence

  busy_flag_a: assert property (
    (st_ff == fpe_pkg::S_BUSY || st_ff == fpe_pkg::S_FAIL) |-> !rdy_ff)
    else $error("ready set while busy");
  fail_hold_a: assert property (
    st_ff == fpe_pkg::S_FAIL |=> (st_ff == fpe_pkg::S_FAIL && !rdy_ff)[*4])
    else $error("failure state left");
  full_start_a: assert property (
    seventh_write_s and (sec_ff && all_prot) |=> array_erase_ff && !rdy_ff)
    else $error("full erase did not start");
  full_done_a: assert property (
    full_last_s |=> stat_word == 32'h0000_0001)
    else $error("status not 0x1 after full erase");
  group_clr_a: assert property (
    busy_end && !full_ff |=> (prot_ff & $past(grp_ff)) == '0 && rdy_ff)
    else $error("group flags not cleared");
  ignore_cmd_a: assert property (
    st_ff == fpe_pkg::S_BUSY && cnt_ff > CW'(2) && !fail_s2_ff
    |=> st_ff == fpe_pkg::S_BUSY && cnt_ff == $past(cnt_ff) - CW'(1))
    else $error("busy sequence disturbed");
  read_mode_a: assert property (
    busy_end && (!full_ff || ph_ff) |=> st_ff == fpe_pkg::S_IDLE && !id_mode_ff)
    else $error("no return to read mode");
  identify_query_a: assert property (
    rd_flash && id_mode_ff |=> rdata_ff == $past(id_word))
    else $error("identify word wrong");
  small_var_a: assert property (
    SMALL_VARIANT |-> stat_word[fpe_pkg::PROT_LO+5:fpe_pkg::PROT_LO+4] == 2'h0)
    else $error("small variant flags nonzero");

endmodule // fpe_ctrl

/* logic/fpe_pkg.sv */
package fpe_pkg;

  // ==========================================================
  // register map (byte offsets, low address byte)
  localparam logic [7:0] OFS_SEC = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h20;
  localparam int RDY_BIT = 0;
  localparam int PROT_LO = 16;
  localparam int NBLK = 6;
  localparam logic SEC_RST = 1'h1;
  localparam logic [NBLK-1:0] GRP0_MASK = 6'h0F;
  localparam logic [NBLK-1:0] GRP1_MASK = 6'h30;
  localparam logic [NBLK-1:0] SMALL_MASK = 6'h0F;
  localparam logic [NBLK-1:0] FULL_MASK = 6'h3F;

  // ==========================================================
  // command cycles: data byte and address bits 15:8
  localparam logic [7:0] CMD_AA = 8'hAA;
  localparam logic [7:0] CMD_55 = 8'h55;
  localparam logic [7:0] CMD_PBE = 8'h6A;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_RST = 8'hF0;
  localparam logic [7:0] ADR_54 = 8'h54;
  localparam logic [7:0] ADR_AA = 8'hAA;
  localparam int ACMD_HI = 15;
  localparam int ACMD_LO = 8;
  localparam int IDSEL_HI = 15;
  localparam int IDSEL_LO = 14;
  localparam int GRP_BIT = 14;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 20;
  localparam int PBE_TIME_US = 100;
  localparam int FULL_TIME_US = 1000;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] PBE_CYC = CNT_W'(PBE_TIME_US * CLK_MHZ);
  localparam logic [1:0] LOAD_DLY = 2'h3;

  // ==========================================================
  // types
  typedef struct packed {
    logic wr;
    logic rd;
    logic reg_sel;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fpe_req_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_C1 = 4'h1,
    S_C2 = 4'h3,
    S_C3 = 4'h2,
    S_C4 = 4'h6,
    S_C5 = 4'h7,
    S_C6 = 4'h5,
    S_BUSY = 4'h4,
    S_FAIL = 4'hC,
    S_IDARM = 4'hB
  } fpe_state_t;

endpackage
